//--- banked_io_tx_control_tb.sv
// self-checking bench for the banked i/o transmit control block
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
module banked_io_tx_control_tb;
  logic ref_clk, rstn, power_down, tx_frame_active, preamble_end;
  logic carrier_sense, collision, sqe_fail, underrun, coll16;
  logic late_collision, early_tx_enable, rx_addr_pass, rx_from_self;
  logic [`BTC_ADDR_W-1:0] dma_tx_addr, host_pointer, load_addr;
  logic [`BTC_ADDR_W-1:0] tx_byte_count;
  logic [`BTC_PKT_W-1:0]  tx_pkt_num, load_pkt_num;
  logic [3:0]  io_addr;
  logic        io_rd, io_wr;
  logic [1:0]  io_be;
  logic [15:0] io_wdata, io_rdata, v;
  logic        crc_append, full_duplex_eff, carrier_monitor_eff;
  logic        defer_enable, collision_detect_en, net_tx_enable;
  logic        internal_loop, local_loop, tx_running, tx_abort_no_crc;
  logic        tx_dma_starve, rx_accept;
  logic [6:0]  pad_len;
  logic        rd_q = 1'b0;
  logic [15:0] exp_q [$];
  int          err_count = 0;
  int          checked = 0;
  wire logic [7:0] eff = {crc_append, full_duplex_eff, carrier_monitor_eff,
    defer_enable, collision_detect_en, net_tx_enable, internal_loop,
    local_loop};

  btc_host_model host_u (.ref_clk, .io_addr, .io_rd, .io_wr, .io_be,
    .io_wdata);
  btc_io_tx_ctrl dut_u (
    .ref_clk, .rstn, .io_addr, .io_rd, .io_wr, .io_be, .io_wdata,
    .power_down, .tx_frame_active, .preamble_end, .carrier_sense,
    .collision, .sqe_fail, .underrun, .coll16, .late_collision,
    .early_tx_enable, .dma_tx_addr, .host_pointer, .load_addr,
    .tx_pkt_num, .load_pkt_num, .rx_addr_pass, .rx_from_self,
    .tx_byte_count, .io_rdata, .crc_append, .full_duplex_eff,
    .carrier_monitor_eff, .defer_enable, .collision_detect_en,
    .net_tx_enable, .internal_loop, .local_loop, .tx_running,
    .tx_abort_no_crc, .tx_dma_starve, .rx_accept, .pad_len
  );

  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    host_u.acc(1'b1, a, be, d);
  endtask
  // expected read data is queued before the access goes out
  task automatic rd(input logic [3:0] a, input logic [1:0] be,
                    input logic [15:0] e);
    exp_q.push_back(e);
    host_u.acc(1'b0, a, be, 16'h0000);
  endtask
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // read data lands on the edge that takes the strobe
  always @(posedge ref_clk) rd_q <= io_rd;
  always @(negedge ref_clk) begin
    if (rd_q && exp_q.size() > 0)
      chk(io_rdata, exp_q.pop_front());
  end

  initial begin
    #60000;
    err_count++;
    end_sim();
  end

  initial begin
    logic [15:0] tv [6] = '{16'h0000, 16'h0100, 16'h8400, 16'h0400,
                            16'h2000, 16'h0402};
    logic [7:0]  te [6] = '{8'h9c, 8'h1c, 8'hc4, 8'hbc, 8'h02, 8'h01};
    logic [7:0]  tm [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h25};
    logic [15:0] rv [3] = '{16'h0000, 16'h0800, 16'h8000};
    logic [15:0] et [5] = '{16'h0001, 16'h1001, 16'h0001, 16'h0001,
                            16'h0001};
    logic [3:0]  ee [5] = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h1};
    logic [15:0] ex [5] = '{16'h0001, 16'h1000, 16'h0000, 16'h0000,
                            16'h0000};
    logic [15:0] st [5] = '{16'h0000, 16'h0000, 16'h4000, 16'h4000,
                            16'h4000};
    logic [10:0] sd [5] = '{11'h200, 11'h050, 11'h200, 11'h400, 11'h400};
    logic [5:0]  sp [5] = '{6'h05, 6'h05, 6'h05, 6'h05, 6'h06};
    logic [10:0] n;
    int          k;
    ref_clk = 1'b0;
    rstn = 1'b0;
    {power_down, tx_frame_active, preamble_end, carrier_sense} = '0;
    {collision, sqe_fail, underrun, coll16, late_collision} = '0;
    {early_tx_enable, rx_addr_pass, rx_from_self} = '0;
    {dma_tx_addr, host_pointer, load_addr, tx_byte_count} = '0;
    {tx_pkt_num, load_pkt_num} = '0;
    void'($urandom(32'h8fcafd02));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(4'he, 2'b11, 16'h3300);
    rd(4'h0, 2'b11, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr(4'h0, 2'b01, v);
      wr(4'h1, 2'b10, v);
      rd(4'h0, 2'b11, v & 16'hfd87);
      rd(4'h1, 2'b10, v & 16'hfd00);
      rd(4'h0, 2'b01, v & 16'h0087);
    end
    $display("byte lane test done");
    for (int i = 0; i < 6; i++) begin
      wr(4'h0, 2'b11, tv[i]);
      settle();
      chk(16'(eff & tm[i]), 16'(te[i]));
    end
    @(posedge ref_clk) {rx_addr_pass, rx_from_self} <= 2'b11;
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 2'b11, rv[i]);
      settle();
      chk(16'(rx_accept), 16'(i != 0));
    end
    $display("mode test done");
    wr(4'he, 2'b01, 16'h0001);
    rd(4'he, 2'b11, 16'h3301);
    rd(4'h0, 2'b11, 16'h0000);
    wr(4'he, 2'b01, 16'h0004);
    rd(4'he, 2'b11, 16'h3304);
    wr(4'h0, 2'b11, 16'hffff);
    rd(4'h0, 2'b11, 16'h3333);
    rd(4'h0, 2'b01, 16'h0033);
    wr(4'he, 2'b11, 16'h0000);
    rd(4'h0, 2'b11, 16'h8000);
    @(posedge ref_clk) power_down <= 1'b1;
    wr(4'he, 2'b01, 16'h0002);
    rd(4'he, 2'b11, 16'h0000);
    @(posedge ref_clk) power_down <= 1'b0;
    rd(4'he, 2'b11, 16'h3300);
    $display("bank test done");
    wr(4'h0, 2'b11, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      n = (i == 2) ? 11'h040 : 11'($urandom_range(63));
      @(posedge ref_clk) tx_byte_count <= n;
      settle();
      chk(16'(pad_len), (i == 2) ? 16'h0000 : 16'(11'h040 - n));
    end
    wr(4'h0, 2'b11, 16'h0000);
    settle();
    chk(16'(pad_len), 16'h0000);
    wr(4'h0, 2'b11, 16'h0004);
    rd(4'h0, 2'b11, 16'h0004);
    @(posedge ref_clk) collision <= 1'b1;
    @(posedge ref_clk) collision <= 1'b0;
    rd(4'h0, 2'b11, 16'h0000);
    $display("pad and collision test done");
    for (int i = 0; i < 5; i++) begin
      wr(4'h0, 2'b11, et[i]);
      @(posedge ref_clk) {sqe_fail, underrun, coll16, late_collision} <= ee[i];
      @(posedge ref_clk) {sqe_fail, underrun, coll16, late_collision} <= '0;
      settle();
      chk(16'(tx_running), 16'(ex[i][0]));
      rd(4'h0, 2'b11, ex[i]);
    end
    wr(4'h0, 2'b11, 16'h0001);
    @(posedge ref_clk) tx_frame_active <= 1'b1;
    wr(4'h0, 2'b11, 16'h0000);
    settle();
    chk(16'(tx_running), 16'h0001);
    @(posedge ref_clk) tx_frame_active <= 1'b0;
    settle();
    chk(16'(tx_running), 16'h0000);
    // carrier never seen by the end of the preamble
    wr(4'h0, 2'b11, 16'h0401);
    @(posedge ref_clk) tx_frame_active <= 1'b1;
    repeat (3) @(posedge ref_clk);
    preamble_end <= 1'b1;
    @(posedge ref_clk) preamble_end <= 1'b0;
    k = 0;
    while (tx_abort_no_crc !== 1'b1 && k < 5) begin
      @(negedge ref_clk);
      k++;
    end
    chk(16'(tx_abort_no_crc), 16'h0001);
    @(posedge ref_clk) tx_frame_active <= 1'b0;
    rd(4'h0, 2'b11, 16'h0400);
    $display("error stop test done");
    @(posedge ref_clk) early_tx_enable <= 1'b1;
    host_pointer <= 11'h100;
    load_addr <= 11'h300;
    tx_pkt_num <= 6'h05;
    for (int i = 0; i < 5; i++) begin
      wr(4'h0, 2'b11, st[i]);
      @(posedge ref_clk) dma_tx_addr <= sd[i];
      load_pkt_num <= sp[i];
      settle();
      chk(16'(tx_dma_starve), 16'(i == 0 || i == 3));
    end
    $display("early transmit test done");
    repeat (3) @(posedge ref_clk);
    end_sim();
  end
endmodule // banked_io_tx_control_tb
`default_nettype wire

//--- btc_ctrl_if.sv
// carrier between register front end and transmit guard
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
interface btc_ctrl_if;
  logic                    mon_en;
  logic                    stop_sqe;
  logic                    early_type;
  logic                    early_tx_enable;
  logic [`BTC_ADDR_W-1:0]  dma_tx_addr;
  logic [`BTC_ADDR_W-1:0]  host_pointer;
  logic [`BTC_ADDR_W-1:0]  load_addr;
  logic [`BTC_PKT_W-1:0]   tx_pkt_num;
  logic [`BTC_PKT_W-1:0]   load_pkt_num;
  logic                    tx_frame_active;
  logic                    preamble_end;
  logic                    carrier_sense;
  logic                    sqe_fail;
  logic                    underrun;
  logic                    coll16;
  logic                    late_collision;
  logic                    stop_req;
  logic                    carrier_fault;
  logic                    starve;
  modport regs (output mon_en, stop_sqe, early_type, early_tx_enable,
    dma_tx_addr, host_pointer, load_addr, tx_pkt_num, load_pkt_num,
    tx_frame_active, preamble_end, carrier_sense, sqe_fail, underrun,
    coll16, late_collision, input stop_req, carrier_fault, starve);
  modport guard (input mon_en, stop_sqe, early_type, early_tx_enable,
    dma_tx_addr, host_pointer, load_addr, tx_pkt_num, load_pkt_num,
    tx_frame_active, preamble_end, carrier_sense, sqe_fail, underrun,
    coll16, late_collision, output stop_req, carrier_fault, starve);
endinterface : btc_ctrl_if
`default_nettype wire

//--- btc_defines.svh
// constants for the banked i/o window and transmit control register
// What this block does
// [RULE1] sixteen locations, four banks, shared bank word
// [RULE2] offset hits low byte or word; odd is high
// [RULE3] word and byte access to every register
// [RULE4] bank field selects 0-3, top bit none
// [RULE5] bank word upper byte always reads 33h; code reads 00h there while powered down
// [RULE6] bank word always reachable except when powered down
// [RULE7] missing bank ignores writes, reads 33h
// [RULE8] crc suppress bit stops crc append
// [RULE9] switched mode forces duplex, drops carrier monitor
// [RULE10] type low: starve dma past host pointer
// [RULE11] type high: match packet, compare load address
// [RULE12] internal loopback keeps data off network
// [RULE13] sqe failure stops transmitter when enabled
// [RULE14] without duplex, reject frames sourced by self
// [RULE15] host writes zero to reserved pause bit
// [RULE16] carrier monitor aborts frame without crc, disables
// [RULE17] pad short frames to 64 with zeros
// [RULE18] force collision skips deferral, self clears
// [RULE19] local loopback ignores collision and carrier, silent
// [RULE20] transmit enable clear finishes frame; errors clear
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH
`define BTC_OFF_TCR      4'h0
`define BTC_OFF_BANK     4'he
`define BTC_BANK_RST     3'h0
`define BTC_BANK_NONE    2
`define BTC_BANK_TX      3'h0
`define BTC_ID_BYTE      8'h33
`define BTC_TCR_RST      16'h0000
`define BTC_TCR_MASK     16'hfd8f
`define BTC_TCR_TRANSMIT_ENABLE    0
`define BTC_TCR_LOOP     1
`define BTC_TCR_FORCE_COLLISION   2
`define BTC_TCR_PAD      7
`define BTC_TCR_CRC_SUPPRESS    8
`define BTC_TCR_MONCS    10
`define BTC_TCR_FULL_DUPLEX   11
`define BTC_TCR_STPSQE   12
`define BTC_TCR_INTLOOP  13
`define BTC_TCR_ETTYPE   14
`define BTC_TCR_SWITCHED_FULL_DUPLEX     15
`define BTC_MIN_FRAME    11'h040
`define BTC_ADDR_W       11
`define BTC_PKT_W        6
`endif

//--- btc_host_model.sv
// host cpu model driving the local i/o bus
`timescale 1ns/1ps
`default_nettype none
module btc_host_model (
  input  wire logic        ref_clk,
  output var  logic [3:0]  io_addr,
  output var  logic        io_rd,
  output var  logic        io_wr,
  output var  logic [1:0]  io_be,
  output var  logic [15:0] io_wdata
);
  initial begin
    io_addr = 4'h0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_be = 2'b00;
    io_wdata = 16'h0000;
  end
  // one-cycle strobe, qualifiers held across the taking edge
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [1:0] be, input logic [15:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_be <= be;
    io_rd <= ~w;
    io_wr <= w;
    // reserved pause bit always written as zero
    io_wdata <= (w && a == 4'h0 && be[0]) ? (d & 16'hfff7) : d;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    // released bus shows the inverse, so stale values never look valid
    io_addr <= ~a;
    io_be <= ~be;
    io_wdata <= ~d;
  endtask
endmodule // btc_host_model
`default_nettype wire

//--- btc_io_tx_ctrl.sv
// banked i/o register window with transmit control register
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
module btc_io_tx_ctrl (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [3:0]             io_addr,
  input  wire logic                   io_rd,
  input  wire logic                   io_wr,
  input  wire logic [1:0]             io_be,
  input  wire logic [15:0]            io_wdata,
  input  wire logic                   power_down,
  input  wire logic                   tx_frame_active,
  input  wire logic                   preamble_end,
  input  wire logic                   carrier_sense,
  input  wire logic                   collision,
  input  wire logic                   sqe_fail,
  input  wire logic                   underrun,
  input  wire logic                   coll16,
  input  wire logic                   late_collision,
  input  wire logic                   early_tx_enable,
  input  wire logic [`BTC_ADDR_W-1:0] dma_tx_addr,
  input  wire logic [`BTC_ADDR_W-1:0] host_pointer,
  input  wire logic [`BTC_ADDR_W-1:0] load_addr,
  input  wire logic [`BTC_PKT_W-1:0]  tx_pkt_num,
  input  wire logic [`BTC_PKT_W-1:0]  load_pkt_num,
  input  wire logic                   rx_addr_pass,
  input  wire logic                   rx_from_self,
  input  wire logic [`BTC_ADDR_W-1:0] tx_byte_count,
  output var  logic [15:0]            io_rdata,
  output var  logic                   crc_append,
  output var  logic                   full_duplex_eff,
  output var  logic                   carrier_monitor_eff,
  output var  logic                   defer_enable,
  output var  logic                   collision_detect_en,
  output var  logic                   net_tx_enable,
  output var  logic                   internal_loop,
  output var  logic                   local_loop,
  output var  logic                   tx_running,
  output var  logic                   tx_abort_no_crc,
  output var  logic                   tx_dma_starve,
  output var  logic                   rx_accept,
  output var  logic [6:0]             pad_len
);
  logic [15:0] transmit_control;
  logic [2:0]  bank;
  logic [15:0] next_tcr;
  logic [2:0]  next_bank;
  logic [15:0] next_rdata;

  btc_ctrl_if ctl ();

  // merge write data into a register on the enabled byte lanes
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic        lo,
    input logic        hi
  );
    lane_merge = {hi ? new_val[15:8] : old_val[15:8],
                  lo ? new_val[7:0]  : old_val[7:0]};
  endfunction

  // keep only the lanes the access names
  function automatic logic [15:0] lane_mask(
    input logic [15:0] val,
    input logic        lo,
    input logic        hi
  );
    lane_mask = {hi ? val[15:8] : 8'h00, lo ? val[7:0] : 8'h00};
  endfunction

  // address decode
  wire [3:0] word_off = {io_addr[3:1], 1'b0}; // RULE2
  wire lane_lo   = !io_addr[0] && io_be[0]; // RULE3
  wire lane_hi   = io_addr[0] || io_be[1]; // RULE2
  wire sel_bank  = word_off == `BTC_OFF_BANK; // RULE1
  wire bank_none = bank[`BTC_BANK_NONE]; // RULE4
  wire sel_tcr   = !sel_bank && !bank_none && (bank == `BTC_BANK_TX) &&
                   (word_off == `BTC_OFF_TCR);
  wire bank_ok   = sel_bank && !power_down; // RULE6
  wire wr_bank   = io_wr && bank_ok;
  wire wr_tcr    = io_wr && sel_tcr; // RULE7
  wire [15:0] id_word   = {`BTC_ID_BYTE, `BTC_ID_BYTE};
  wire [15:0] bank_word = {`BTC_ID_BYTE, 5'h00, bank}; // RULE5
  wire [15:0] tcr_word  = transmit_control & `BTC_TCR_MASK;

  // read data word before lane masking
  wire [15:0] rd_word =
    sel_bank  ? (power_down ? 16'h0000 : bank_word) :
    bank_none ? id_word :
    sel_tcr   ? tcr_word : 16'h0000; // RULE7

  // byte access to the odd half moves data from the high lane
  wire [15:0] wr_word = lane_merge(transmit_control, io_wdata, lane_lo, lane_hi) &
                        `BTC_TCR_MASK;
  wire [15:0] bank_in = lane_merge(bank_word, io_wdata, lane_lo, lane_hi);

  // transmit side wiring to the guard
  assign ctl.mon_en          = carrier_monitor_eff;
  assign ctl.stop_sqe        = transmit_control[`BTC_TCR_STPSQE];
  assign ctl.early_type      = transmit_control[`BTC_TCR_ETTYPE];
  assign ctl.early_tx_enable = early_tx_enable;
  assign ctl.dma_tx_addr     = dma_tx_addr;
  assign ctl.host_pointer    = host_pointer;
  assign ctl.load_addr       = load_addr;
  assign ctl.tx_pkt_num      = tx_pkt_num;
  assign ctl.load_pkt_num    = load_pkt_num;
  assign ctl.tx_frame_active = tx_frame_active;
  assign ctl.preamble_end    = preamble_end;
  assign ctl.carrier_sense   = carrier_sense;
  assign ctl.sqe_fail        = sqe_fail;
  assign ctl.underrun        = underrun;
  assign ctl.coll16          = coll16;
  assign ctl.late_collision  = late_collision;

  btc_tx_guard u_guard (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ctl     (ctl)
  );

  wire stop_req = ctl.stop_req;

  // effective mode decode
  wire switched_full_duplex      = transmit_control[`BTC_TCR_SWITCHED_FULL_DUPLEX];
  wire lloop     = transmit_control[`BTC_TCR_LOOP];
  wire next_fdx  = switched_full_duplex || transmit_control[`BTC_TCR_FULL_DUPLEX]; // RULE9
  wire next_mon  = transmit_control[`BTC_TCR_MONCS] && !switched_full_duplex && !lloop; // RULE9
  wire next_def  = !switched_full_duplex && !transmit_control[`BTC_TCR_FORCE_COLLISION]; // RULE18
  wire next_cdet = !switched_full_duplex && !lloop; // RULE19
  wire next_net  = !transmit_control[`BTC_TCR_INTLOOP] && !lloop; // RULE12
  wire next_acc  = rx_addr_pass && (next_fdx || !rx_from_self); // RULE14
  wire short_frm = tx_byte_count < `BTC_MIN_FRAME;
  // pad count is based on the unpadded count the host wrote
  wire [6:0] next_pad = (transmit_control[`BTC_TCR_PAD] && short_frm) ?
    7'(`BTC_MIN_FRAME - tx_byte_count) : 7'h00; // RULE17

  // a frame in flight finishes after enable drops; errors end it now
  wire next_run = !stop_req &&
    (transmit_control[`BTC_TCR_TRANSMIT_ENABLE] || (tx_running && tx_frame_active)); // RULE20

  always_comb begin
    next_tcr = wr_tcr ? wr_word : transmit_control;
    // a write in the same cycle loads the forced collision bit from the write data, ahead of the collision clear
    next_tcr[`BTC_TCR_FORCE_COLLISION] = wr_tcr ? wr_word[`BTC_TCR_FORCE_COLLISION] :
      (transmit_control[`BTC_TCR_FORCE_COLLISION] && !collision); // RULE18
    // error stop beats a same-cycle enable write
    if (stop_req) begin
      next_tcr[`BTC_TCR_TRANSMIT_ENABLE] = 1'b0; // RULE20
    end
  end

  always_comb begin
    next_bank = wr_bank ? bank_in[2:0] : bank; // RULE4
  end

  always_comb begin
    next_rdata = io_rd ? lane_mask(rd_word, lane_lo, lane_hi) : io_rdata;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      transmit_control      <= `BTC_TCR_RST;
      bank     <= `BTC_BANK_RST;
      io_rdata <= 16'h0000;
    end else begin
      transmit_control      <= next_tcr;
      bank     <= next_bank;
      io_rdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      crc_append          <= 1'b1;
      full_duplex_eff     <= 1'b0;
      carrier_monitor_eff <= 1'b0;
      defer_enable        <= 1'b1;
      collision_detect_en <= 1'b1;
      net_tx_enable       <= 1'b1;
      internal_loop       <= 1'b0;
      local_loop          <= 1'b0;
    end else begin
      crc_append          <= !transmit_control[`BTC_TCR_CRC_SUPPRESS]; // RULE8
      full_duplex_eff     <= next_fdx;
      carrier_monitor_eff <= next_mon;
      defer_enable        <= next_def;
      collision_detect_en <= next_cdet;
      net_tx_enable       <= next_net;
      internal_loop       <= transmit_control[`BTC_TCR_INTLOOP]; // RULE12
      local_loop          <= lloop; // RULE19
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_running      <= 1'b0;
      tx_abort_no_crc <= 1'b0;
      tx_dma_starve   <= 1'b0;
      rx_accept       <= 1'b0;
      pad_len         <= 7'h00;
    end else begin
      tx_running      <= next_run;
      tx_abort_no_crc <= ctl.carrier_fault; // RULE16
      tx_dma_starve   <= ctl.starve;
      rx_accept       <= next_acc;
      pad_len         <= next_pad;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_transmit_enable_err_clear: assert property (stop_req |=> !transmit_control[`BTC_TCR_TRANSMIT_ENABLE] &&
    !tx_running) // RULE20
    else $error("error stop left transmit enabled");
  a_bank_id_read: assert property ((io_rd && sel_bank && !power_down &&
    lane_hi) |=> io_rdata[15:8] == `BTC_ID_BYTE) // RULE5
    else $error("bank word upper byte not 33h");
  a_none_no_write: assert property ((io_wr && bank_none && !sel_bank &&
    !stop_req && !collision) |=> $stable(transmit_control)) // RULE7
    else $error("write landed in a missing bank");
  a_none_read33: assert property ((io_rd && bank_none && !sel_bank &&
    lane_lo) |=> io_rdata[7:0] == `BTC_ID_BYTE) // RULE7
    else $error("missing bank byte read not 33h");
  a_bank_pd_lock: assert property ((power_down && io_wr && sel_bank)
    |=> $stable(bank)) // RULE6
    else $error("bank word written while powered down");
  a_switched_full_duplex_forces: assert property (switched_full_duplex |=> full_duplex_eff &&
    !carrier_monitor_eff && !defer_enable) // RULE9
    else $error("switched mode did not force duplex");
  a_loop_quiet: assert property ((transmit_control[`BTC_TCR_INTLOOP] || lloop)
    |=> !net_tx_enable) // RULE12
    else $error("loopback still sends to network");
  a_own_reject: assert property ((rx_addr_pass && rx_from_self &&
    !transmit_control[`BTC_TCR_FULL_DUPLEX] && !switched_full_duplex) |=> !rx_accept) // RULE14
    else $error("own frame accepted without duplex");
  a_force_collision_clear: assert property ((transmit_control[`BTC_TCR_FORCE_COLLISION] && collision &&
    !wr_tcr) |=> !transmit_control[`BTC_TCR_FORCE_COLLISION] ##1 defer_enable || switched_full_duplex) // RULE18
    else $error("forced collision bit not cleared");
  a_crc_default: assert property (transmit_control[`BTC_TCR_CRC_SUPPRESS] |=> !crc_append) // RULE8
    else $error("crc still appended while suppressed");

  c_bank_switch: cover property (wr_bank ##1 bank != $past(bank));
  c_err_stop: cover property (transmit_control[`BTC_TCR_TRANSMIT_ENABLE] ##1 stop_req);
  c_force_collision_hit: cover property (transmit_control[`BTC_TCR_FORCE_COLLISION] && collision);
  c_none_read: cover property (io_rd && bank_none && !sel_bank);
endmodule : btc_io_tx_ctrl
`default_nettype wire

//--- btc_pkg.sv
// types shared by the transmit control front end
package btc_pkg;
  typedef enum logic [1:0] {
    MON_IDLE,
    MON_PRE,
    MON_BODY,
    MON_HOLD
  } btc_mon_state_type;
endpackage : btc_pkg

//--- btc_tx_guard.sv
// carrier monitor, error stop and early transmit underrun guard
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
module btc_tx_guard (
  input wire logic ref_clk,
  input wire logic rstn,
  btc_ctrl_if.guard ctl
);
  btc_pkg::btc_mon_state_type state;
  btc_pkg::btc_mon_state_type next_state;
  logic                       fault;
  logic                       starve;

  wire hit_ptr  = ctl.dma_tx_addr > ctl.host_pointer; // RULE10
  wire pkt_same = ctl.tx_pkt_num == ctl.load_pkt_num;
  wire hit_pkt  = pkt_same && (ctl.dma_tx_addr > ctl.load_addr); // RULE11
  wire next_starve = ctl.early_tx_enable &&
                     (ctl.early_type ? hit_pkt : hit_ptr);

  // own carrier must be up at preamble end and stay up
  always_comb begin
    next_state = state;
    fault      = 1'b0;
    case (state)
      btc_pkg::MON_IDLE: begin
        if (ctl.tx_frame_active && ctl.mon_en) begin
          next_state = btc_pkg::MON_PRE;
        end
      end
      btc_pkg::MON_PRE: begin
        if (!ctl.tx_frame_active) begin
          next_state = btc_pkg::MON_IDLE;
        end else if (ctl.preamble_end) begin
          fault      = !ctl.carrier_sense; // RULE16
          next_state = ctl.carrier_sense ? btc_pkg::MON_BODY
                                         : btc_pkg::MON_HOLD;
        end
      end
      btc_pkg::MON_BODY: begin
        if (!ctl.tx_frame_active) begin
          next_state = btc_pkg::MON_IDLE;
        end else if (!ctl.carrier_sense) begin
          fault      = 1'b1; // RULE16
          next_state = btc_pkg::MON_HOLD;
        end
      end
      default: begin
        // one abort per frame; wait for the frame to drop
        if (!ctl.tx_frame_active) begin
          next_state = btc_pkg::MON_IDLE;
        end
      end
    endcase
  end

  assign ctl.carrier_fault = fault;
  assign ctl.stop_req = ctl.underrun || ctl.coll16 || ctl.late_collision ||
                        (ctl.sqe_fail && ctl.stop_sqe) || fault; // RULE13
  assign ctl.starve = starve;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state  <= btc_pkg::MON_IDLE;
      starve <= 1'b0;
    end else begin
      state  <= next_state;
      starve <= next_starve;
    end
  end

  a_starve_ptr: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ctl.early_tx_enable && !ctl.early_type && hit_ptr) |=> starve) // RULE10
    else $error("early transmit did not starve dma");
  a_carrier_abort: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == btc_pkg::MON_PRE && ctl.tx_frame_active && ctl.preamble_end
     && !ctl.carrier_sense) |-> ctl.stop_req) // RULE16
    else $error("missing carrier did not stop transmitter");
endmodule : btc_tx_guard
`default_nettype wire
